// ===== vmos_valve_output.sv
// Mode-selected valve output logic of the weld sequence control
// Operation
// - Mode 06: output on half second after end
// - Mode 07: air-over-oil retraction drives output
// - Mode 08 retraction, mode 09 half cycle weld
// - Mode 10: on for errors, stop, no-weld states
// - Mode 11: on while temperature switch open, code 01
// - Mode 12: flash hi/lo when out of window
// - Mode 13: flash and valve 3 half second
// - Mode 14: flash and abort the sequence
// - Mode 15: on for hardware or relay error
// - Mode 16: on for thyristor short, code 25
// - Mode 17: on for assorted control faults
// - Mode 18: on for full conduction, code 13
// - Mode 19: on in weld with input closed
// - Mode 20: on after squeeze through weld
// - Mode 22: report after bad or last weld
// - Mode 23: report only when out of window
// - Mode 25: show hi/lo, end and current
// - Mode 26: flash and halt in hold
// - Mode 27: flash, abort, valve 3 half second
// - Mode 28: show end, valve 3 half second on good weld
//
// Design decisions made here: the placing of the registers and the strobed register port.
module vmos_valve_output
    import vmos_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int FLASH_CYCLES = FLASH_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire vmos_seq_s seq,
    output vmos_out_s outs
);

    localparam int FW = $clog2(FLASH_CYCLES + 1);
    localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

    // Whole state of the block apart from the two pulse timers
    typedef struct packed {
        logic [7:0] mode;        // Selected mode code
        logic oow;               // Last result out of window
        vmos_lock_e lock;        // Interlock tracker
        logic [FW-1:0] flash_cnt; // Flash half-period divider
        logic flash;             // Flash phase
        logic [CUR_W-1:0] cur;   // Last measured current
        logic [31:0] rdata;      // Read data for the cycle after a read
        vmos_out_s o;            // Registered outputs
    } vmos_state_s;

    vmos_state_s st_r;
    vmos_state_s st_nxt;

    logic p6_start; // Start of the end-of-sequence pulse
    logic p6_busy;
    logic p3_start; // Start of a valve 3 pulse
    logic p3_busy;
    logic oow_evt;  // Fresh out-of-window result
    logic flash_mode; // Mode flashes the hi/lo lamp

    // Refuse rates that the divider and timers cannot serve
    generate
        if (PULSE_CYCLES < 1 || FLASH_CYCLES < 2) begin : g_chk
            $error("vmos_valve_output: cycle counts too small");
        end
    endgenerate

    // Flash-style modes share the divider
    function automatic logic is_flash(input logic [7:0] m);
        return m == MODE_FLASH || m == MODE_FLASH_V3 || m == MODE_FLASH_ABORT
            || m == MODE_HOLD_STOP || m == MODE_ABORT_V3;
    endfunction

    // Error display code, worst fault first
    function automatic logic [7:0] err_code(input vmos_seq_s s);
        if (s.temp_switch_open) begin
            return ERR_TEMP;
        end else if (s.full_conduction) begin
            return ERR_FULL_COND;
        end else if (s.shorted_thyristor || s.second_supply_line_missing) begin
            return ERR_THYRISTOR;
        end
        return ERR_NONE;
    endfunction

    assign oow_evt = seq.meas_valid && seq.out_of_window;
    assign flash_mode = is_flash(st_r.mode);

    // Pulse triggers; mode 28 needs a good weld in weld mode with the input closed
    always_comb begin
        p6_start = (st_r.mode == MODE_EOS_PULSE) && seq.end_of_sequence;
        p3_start = ((st_r.mode == MODE_FLASH_V3 || st_r.mode == MODE_ABORT_V3)
                    && oow_evt)
            || (st_r.mode == MODE_EOS_V3 && seq.end_of_sequence && !st_r.oow
                && seq.weld_mode && seq.no_weld_input_one_closed);
    end

    // Half-second output pulse for mode 06
    vmos_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_eos_pulse (
        .clk(clk),
        .rst_b(rst_b),
        .start(p6_start),
        .busy(p6_busy)
    );

    // Half-second valve 3 pulse shared by modes 13, 27 and 28
    vmos_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_valve3_pulse (
        .clk(clk),
        .rst_b(rst_b),
        .start(p3_start),
        .busy(p3_busy)
    );

    // Next state: registers, result latch, interlock, flash and outputs
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = '0;
        // Single mode register, so one code per output
        if (wr && addr == OFS_MODE) begin
            st_nxt.mode = wdata[7:0];
        end
        // Software clear loses to a new result in the same cycle
        if (seq.seq_start || (wr && addr == OFS_STATUS && wdata[ST_OOW])) begin
            st_nxt.oow = 1'b0;
        end
        if (seq.meas_valid) begin
            st_nxt.oow = seq.out_of_window;
            st_nxt.cur = seq.current;
        end
        // Interlock: arm in squeeze, on when squeeze ends, off when weld ends
        unique case (st_r.lock)
            LOCK_IDLE: begin
                if (seq.in_squeeze) begin
                    st_nxt.lock = LOCK_SQZ;
                end
            end
            LOCK_SQZ: begin
                if (!seq.in_squeeze) begin
                    st_nxt.lock = LOCK_ON;
                end
            end
            LOCK_ON: begin
                if (!seq.in_weld) begin
                    st_nxt.lock = LOCK_IDLE;
                end
            end
            default: begin
                st_nxt.lock = LOCK_IDLE;
            end
        endcase
        // Flash divider runs only while flashing is due
        if (flash_mode && oow_evt) begin
            // A fresh bad result restarts the blink lit, even mid-flash
            st_nxt.flash_cnt = '0;
            st_nxt.flash = 1'b1;
        end else if (flash_mode && st_nxt.oow) begin
            if (st_r.flash_cnt == FLASH_LAST) begin
                st_nxt.flash_cnt = '0;
                st_nxt.flash = !st_r.flash;
            end else begin
                st_nxt.flash_cnt = st_r.flash_cnt + 1'b1;
            end
        end else begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash = 1'b1; // Lamp lights at once on a fresh result
        end
        // Outputs, cleared then set by the selected mode
        st_nxt.o = '0;
        st_nxt.o.error_code_display = err_code(seq);
        st_nxt.o.report_current = seq.meas_valid ? seq.current : st_r.cur;
        st_nxt.o.hi_lo_indicator = flash_mode && st_nxt.oow
            && st_nxt.flash;
        case (st_r.mode)
            MODE_EOS_PULSE: begin
                st_nxt.o.valve_out = p6_busy;
            end
            MODE_AIR_OIL: begin
                st_nxt.o.air_oil_retract = 1'b1;
                st_nxt.o.valve_out = seq.retract_req;
            end
            MODE_RETRACT: begin
                st_nxt.o.retraction_mode = 1'b1;
                st_nxt.o.valve_out = seq.retract_req;
            end
            MODE_HALF_CYC: begin
                st_nxt.o.half_cycle_mode = 1'b1;
            end
            MODE_ANY_ERR: begin
                st_nxt.o.valve_out = seq.any_error || seq.no_weld || seq.program_mode
                    || seq.emergency_stop
                    || (seq.constant_current && st_nxt.oow);
            end
            MODE_TEMP: begin
                st_nxt.o.valve_out = seq.temp_switch_open;
            end
            MODE_FLASH_V3: begin
                st_nxt.o.valve3 = p3_busy;
            end
            MODE_FLASH_ABORT: begin
                st_nxt.o.abort_seq = oow_evt;
            end
            MODE_HW_ERR: begin
                st_nxt.o.valve_out = seq.hardware_error || seq.relay_error;
            end
            MODE_THY_ERR: begin
                st_nxt.o.valve_out = seq.shorted_thyristor
                    || seq.second_supply_line_missing;
            end
            MODE_MISC_ERR: begin
                st_nxt.o.valve_out = seq.temperature_limit_switch_error
                    || seq.memory_error || seq.automatic_compensation_error
                    || seq.end_of_stepper;
            end
            MODE_FULL_COND: begin
                st_nxt.o.valve_out = seq.full_conduction;
            end
            MODE_WELD_ONLY: begin
                st_nxt.o.valve_out = seq.in_weld && seq.weld_mode
                    && seq.no_weld_input_one_closed;
            end
            MODE_INTERLOCK: begin
                st_nxt.o.valve_out = (st_nxt.lock == LOCK_ON);
            end
            MODE_SEND_LAST: begin
                st_nxt.o.report_req = seq.meas_valid
                    && (seq.out_of_window || seq.last_weld);
            end
            MODE_SEND_OOW: begin
                st_nxt.o.report_req = oow_evt;
            end
            MODE_SHOW: begin
                st_nxt.o.hi_lo_steady = st_nxt.oow;
                st_nxt.o.eos_indicate = seq.end_of_sequence;
                st_nxt.o.display_current_en = 1'b1;
            end
            MODE_HOLD_STOP: begin
                st_nxt.o.halt_in_hold = st_nxt.oow;
            end
            MODE_ABORT_V3: begin
                st_nxt.o.abort_seq = oow_evt;
                st_nxt.o.valve3 = p3_busy;
            end
            MODE_EOS_V3: begin
                st_nxt.o.eos_indicate = seq.end_of_sequence;
                st_nxt.o.valve3 = p3_busy;
            end
            default: begin
                // Reserved, unlisted and flash-only codes leave the valve off
                st_nxt.o.valve_out = 1'b0;
            end
        endcase
        // Read data for the cycle after the strobe; unmapped reads give zero
        if (rd) begin
            unique case (addr)
                OFS_MODE: st_nxt.rdata = {24'h000000, st_r.mode};
                OFS_STATUS: st_nxt.rdata = {27'h0000000,
                    st_r.lock == LOCK_ON, st_r.o.hi_lo_indicator, st_r.oow,
                    st_r.o.valve3, st_r.o.valve_out};
                OFS_CURRENT: st_nxt.rdata = {16'h0000, st_r.cur};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{mode: MODE_RESET, lock: LOCK_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign outs = st_r.o;

    // Checks of the mode behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Mode held for the two cycles that shape the output, so a legal rewrite
    // of the mode right after the trigger does not count as a fault
    sequence s_eos6;
        (st_r.mode == MODE_EOS_PULSE && seq.end_of_sequence && !wr) ##1 !wr;
    endsequence

    sequence s_good28;
        (st_r.mode == MODE_EOS_V3 && seq.end_of_sequence && !st_r.oow
            && seq.weld_mode && seq.no_weld_input_one_closed && !wr) ##1 !wr;
    endsequence

    sequence s_bad27;
        st_r.mode == MODE_ABORT_V3 && oow_evt && !wr;
    endsequence

    AST_EOS_PULSE: assert property (s_eos6 |-> ##1 outs.valve_out[*2])
        else $error("mode 06 pulse missing after end of sequence");

    AST_ANY_ERR: assert property (st_r.mode == MODE_ANY_ERR && !wr
        && seq.emergency_stop |=> outs.valve_out)
        else $error("mode 10 output off during emergency stop");

    AST_TEMP: assert property (st_r.mode == MODE_TEMP && !wr
        && seq.temp_switch_open |=> outs.valve_out
        && outs.error_code_display == ERR_TEMP)
        else $error("mode 11 output or code wrong");

    AST_FLASH_OFF: assert property (!st_r.oow |-> !outs.hi_lo_indicator)
        else $error("hi/lo lamp on without a bad result");

    AST_ABORT14: assert property (st_r.mode == MODE_FLASH_ABORT && !wr
        && oow_evt |=> outs.abort_seq ##1 outs.hi_lo_indicator)
        else $error("mode 14 did not abort on a bad result");

    AST_WELD19: assert property (st_r.mode == MODE_WELD_ONLY
        && !seq.weld_mode |=> !outs.valve_out)
        else $error("mode 19 output outside weld mode");

    AST_SEND23: assert property (st_r.mode == MODE_SEND_OOW && !wr
        && seq.meas_valid |=> outs.report_req == $past(seq.out_of_window))
        else $error("mode 23 report does not follow the result");

    AST_HOLD26: assert property (st_r.mode == MODE_HOLD_STOP && !wr
        && oow_evt |=> outs.halt_in_hold)
        else $error("mode 26 did not halt in hold");

    AST_ABORT27: assert property (s_bad27 |=> outs.abort_seq
        ##1 outs.valve3)
        else $error("mode 27 abort or valve 3 missing");

    AST_GOOD28: assert property (s_good28 |-> outs.eos_indicate
        ##1 outs.valve3[*2])
        else $error("mode 28 valve 3 pulse missing");

    AST_RESERVED: assert property ((st_r.mode == 8'h21 || st_r.mode == 8'h29)
        && !wr |=> !outs.valve_out && !outs.valve3)
        else $error("reserved mode drove an output");

endmodule

// ===== vmos_pkg.sv
// Shared constants, carriers and state codes of the valve output mode select block
package vmos_pkg;

    // System clock and the documented pulse time
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_TIME_MS = 500;
    localparam int PULSE_CYC = PULSE_TIME_MS * (CLK_HZ / 1000);
    // Half period of the hi/lo flash, chosen for a readable blink
    localparam int FLASH_TIME_MS = 250;
    localparam int FLASH_CYC = FLASH_TIME_MS * (CLK_HZ / 1000);

    // Register port geometry and offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CURRENT = 4'h8;

    // Status register bit positions
    localparam int ST_VALVE = 0;
    localparam int ST_VALVE3 = 1;
    localparam int ST_OOW = 2;
    localparam int ST_FLASH = 3;
    localparam int ST_LOCK = 4;

    // Mode codes, held as two BCD digits
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_EOS_PULSE = 8'h06;
    localparam logic [7:0] MODE_AIR_OIL = 8'h07;
    localparam logic [7:0] MODE_RETRACT = 8'h08;
    localparam logic [7:0] MODE_HALF_CYC = 8'h09;
    localparam logic [7:0] MODE_ANY_ERR = 8'h10;
    localparam logic [7:0] MODE_TEMP = 8'h11;
    localparam logic [7:0] MODE_FLASH = 8'h12;
    localparam logic [7:0] MODE_FLASH_V3 = 8'h13;
    localparam logic [7:0] MODE_FLASH_ABORT = 8'h14;
    localparam logic [7:0] MODE_HW_ERR = 8'h15;
    localparam logic [7:0] MODE_THY_ERR = 8'h16;
    localparam logic [7:0] MODE_MISC_ERR = 8'h17;
    localparam logic [7:0] MODE_FULL_COND = 8'h18;
    localparam logic [7:0] MODE_WELD_ONLY = 8'h19;
    localparam logic [7:0] MODE_INTERLOCK = 8'h20;
    localparam logic [7:0] MODE_SEND_LAST = 8'h22;
    localparam logic [7:0] MODE_SEND_OOW = 8'h23;
    localparam logic [7:0] MODE_SHOW = 8'h25;
    localparam logic [7:0] MODE_HOLD_STOP = 8'h26;
    localparam logic [7:0] MODE_ABORT_V3 = 8'h27;
    localparam logic [7:0] MODE_EOS_V3 = 8'h28;

    // Error codes for the error display
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_TEMP = 8'h01;
    localparam logic [7:0] ERR_FULL_COND = 8'h13;
    localparam logic [7:0] ERR_THYRISTOR = 8'h25;

    localparam int CUR_W = 16;

    // Interlock tracker states
    typedef enum logic [2:0] {
        LOCK_IDLE = 3'b001,
        LOCK_SQZ = 3'b010,
        LOCK_ON = 3'b100
    } vmos_lock_e;

    // Signals from the sequencer, fault and current monitors
    typedef struct packed {
        logic end_of_sequence;
        logic seq_start;
        logic in_squeeze;
        logic in_weld;
        logic weld_mode;
        logic no_weld_input_one_closed;
        logic retract_req;
        logic any_error;
        logic no_weld;
        logic program_mode;
        logic emergency_stop;
        logic constant_current;
        logic meas_valid;
        logic out_of_window;
        logic last_weld;
        logic temp_switch_open;
        logic hardware_error;
        logic relay_error;
        logic shorted_thyristor;
        logic second_supply_line_missing;
        logic temperature_limit_switch_error;
        logic memory_error;
        logic automatic_compensation_error;
        logic end_of_stepper;
        logic full_conduction;
        logic [CUR_W-1:0] current;
    } vmos_seq_s;

    // Everything the block drives except the read data
    typedef struct packed {
        logic valve_out;
        logic valve3;
        logic hi_lo_indicator;
        logic hi_lo_steady;
        logic eos_indicate;
        logic abort_seq;
        logic halt_in_hold;
        logic retraction_mode;
        logic half_cycle_mode;
        logic air_oil_retract;
        logic report_req;
        logic display_current_en;
        logic [7:0] error_code_display;
        logic [CUR_W-1:0] report_current;
    } vmos_out_s;

endpackage

// ===== vmos_pulse_timer.sv
// Retriggerable one-shot that times the half-second valve pulses
module vmos_pulse_timer
    import vmos_pkg::*;
#(
    parameter int CYCLES = PULSE_CYC,
    parameter int CW = $clog2(CYCLES + 1)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    output logic busy
);

    // Whole state: the remaining cycle count
    typedef struct packed {
        logic [CW-1:0] cnt;
    } vmos_tmr_s;

    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    vmos_tmr_s st_r;
    vmos_tmr_s st_nxt;

    // A zero length pulse cannot be timed
    generate
        if (CYCLES < 1) begin : g_chk
            $error("vmos_pulse_timer: CYCLES must be at least 1");
        end
    endgenerate

    // Load on start, then count down to zero
    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.cnt = LOAD;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Busy for exactly CYCLES cycles after the last start
    assign busy = (st_r.cnt != '0);

    AST_TMR_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        start |=> busy && st_r.cnt == LOAD)
        else $error("timer did not load on start");

    AST_TMR_END: assert property (@(posedge clk) disable iff (!rst_b)
        (st_r.cnt == 1 && !start) |=> !busy)
        else $error("timer ran past its end");

endmodule

// ===== vmos_seq_model.sv
// Behavioural weld sequencer, fault monitors and current monitor for the bench
module vmos_seq_model
    import vmos_pkg::*;
(
    input wire logic clk,
    output vmos_seq_s seq
);
    timeunit 1ns;
    timeprecision 1ns;

    // Every line idle low at time zero
    initial begin
        seq = '0;
    end

    // Two lines changed at one edge; k counts fields from end_of_sequence as 0
    task automatic set2(input int k1, input logic v1, input int k2, input logic v2);
        @(posedge clk);
        seq[CUR_W+24-k1] <= v1;
        seq[CUR_W+24-k2] <= v2;
    endtask

    // One level line
    task automatic set_lvl(input int k, input logic v);
        @(posedge clk);
        seq[CUR_W+24-k] <= v;
    endtask

    // One-cycle event such as end_of_sequence or seq_start
    task automatic pulse(input int k);
        set_lvl(k, 1'b1);
        set_lvl(k, 1'b0);
    endtask

    // Measurement; data lines are scrambled once the strobe drops,
    // so the block cannot lean on stale values
    task automatic meas(input logic oow, input logic last, input logic [CUR_W-1:0] cur);
        @(posedge clk);
        seq.meas_valid <= 1'b1;
        seq.out_of_window <= oow;
        seq.last_weld <= last;
        seq.current <= cur;
        @(posedge clk);
        seq.meas_valid <= 1'b0;
        seq.out_of_window <= ~oow;
        seq.last_weld <= ~last;
        seq.current <= ~cur;
    endtask
endmodule

// ===== vmos_valve_output_tb_top.sv
// Self-checking bench for the valve output mode select block
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module vmos_valve_output_tb_top
    import vmos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PC = 16; // Shortened half-second pulse
    localparam int FC = 4; // Shortened flash half period
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    vmos_seq_s seq;
    vmos_out_s outs;
    int err_total = 0;
    int num_checks = 0;

    vmos_valve_output #(.PULSE_CYCLES(PC), .FLASH_CYCLES(FC)) DUT (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .seq(seq), .outs(outs));
    vmos_seq_model SEQ (.clk(clk), .seq(seq));

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end

    // Wait n edges, then sample mid-cycle where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Caller stands in the cycle after the trigger edge
    task automatic pulse_chk(input bit v3);
        `CHK("pulse early", 1'b0, v3 ? outs.valve3 : outs.valve_out)
        settle(1);
        `CHK("pulse on", 1'b1, v3 ? outs.valve3 : outs.valve_out)
        settle(PC - 1);
        `CHK("pulse last", 1'b1, v3 ? outs.valve3 : outs.valve_out)
        settle(1);
        `CHK("pulse off", 1'b0, v3 ? outs.valve3 : outs.valve_out)
    endtask

    task automatic t_regs();
        logic [31:0] d;
        reg_rd(OFS_MODE, d);
        `CHK("mode reset", 32'h0, d)
        reg_wr(OFS_MODE, 32'h13);
        reg_rd(OFS_MODE, d);
        `CHK("mode readback", 32'h13, d)
        settle(0);
        `CHK("rdata idle", 32'h0, rdata)
        reg_wr(4'hC, 32'hFF);
        reg_rd(4'hC, d);
        `CHK("unmapped", 32'h0, d)
        $display("test regs done");
    endtask

    // Each fault level in its mode, then the same fault under a reserved code
    task automatic t_levels();
        logic [7:0] md[14] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h11, 8'h15, 8'h15,
            8'h16, 8'h16, 8'h17, 8'h17, 8'h17, 8'h17, 8'h18};
        int kk[14] = '{7, 8, 9, 10, 15, 16, 17, 18, 19, 20, 21, 22, 23, 24};
        logic [7:0] ec[14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
            8'h25, 8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'h13};
        for (int i = 0; i < 14; i++) begin
            reg_wr(OFS_MODE, {24'h0, md[i]});
            SEQ.set_lvl(kk[i], 1'b1);
            settle(1);
            `CHK("fault on", 1'b1, outs.valve_out)
            if (ec[i] != 8'h00) begin
                `CHK("error code", ec[i], outs.error_code_display)
            end
            reg_wr(OFS_MODE, {24'h0, i[0] ? 8'h21 : 8'h29});
            settle(1);
            `CHK("reserved off", 1'b0, outs.valve_out)
            SEQ.set_lvl(kk[i], 1'b0);
        end
        $display("test levels done");
    endtask

    // Out-of-window reactions of the flash modes
    task automatic t_oow();
        logic [7:0] md[5] = '{8'h12, 8'h13, 8'h14, 8'h26, 8'h27};
        logic [31:0] d;
        for (int i = 0; i < 5; i++) begin
            reg_wr(OFS_MODE, {24'h0, md[i]});
            SEQ.meas(1'b1, 1'b0, 16'h1234);
            settle(0);
            `CHK("lamp on", 1'b1, outs.hi_lo_indicator)
            `CHK("abort", md[i] == 8'h14 || md[i] == 8'h27, outs.abort_seq)
            `CHK("halt", md[i] == 8'h26, outs.halt_in_hold)
            if (md[i] == 8'h13 || md[i] == 8'h27) begin
                pulse_chk(1'b1);
            end else begin
                settle(1);
                `CHK("no valve3", 1'b0, outs.valve3)
                settle(FC - 1);
                `CHK("lamp flash", 1'b0, outs.hi_lo_indicator)
            end
        end
        reg_rd(OFS_STATUS, d);
        `CHK("latch set", 1'b1, d[ST_OOW])
        reg_rd(OFS_CURRENT, d);
        `CHK("current", 32'h1234, d)
        reg_wr(OFS_STATUS, 32'h4);
        reg_rd(OFS_STATUS, d);
        `CHK("latch clear", 1'b0, d[ST_OOW])
        $display("test out of window done");
    endtask

    // End-of-sequence pulses, weld-phase and interlock modes
    task automatic t_seq();
        reg_wr(OFS_MODE, 32'h06);
        SEQ.pulse(0);
        settle(0);
        pulse_chk(1'b0);
        reg_wr(OFS_MODE, 32'h28);
        SEQ.pulse(1);
        SEQ.set2(4, 1'b1, 5, 1'b1);
        SEQ.pulse(0);
        settle(0);
        `CHK("eos good", 1'b1, outs.eos_indicate)
        pulse_chk(1'b1);
        SEQ.set_lvl(5, 1'b0);
        SEQ.pulse(0);
        settle(1);
        `CHK("eos open input", 1'b0, outs.valve3)
        reg_wr(OFS_MODE, 32'h19);
        SEQ.set2(5, 1'b1, 3, 1'b1);
        settle(1);
        `CHK("weld only on", 1'b1, outs.valve_out)
        SEQ.set_lvl(4, 1'b0);
        settle(1);
        `CHK("weld only off", 1'b0, outs.valve_out)
        SEQ.set_lvl(3, 1'b0);
        reg_wr(OFS_MODE, 32'h20);
        SEQ.set_lvl(2, 1'b1);
        settle(1);
        `CHK("squeeze off", 1'b0, outs.valve_out)
        SEQ.set2(2, 1'b0, 3, 1'b1);
        settle(2);
        `CHK("interlock on", 1'b1, outs.valve_out)
        SEQ.set_lvl(3, 1'b0);
        settle(2);
        `CHK("interlock off", 1'b0, outs.valve_out)
        $display("test sequence done");
    endtask

    // Retraction and half-cycle modes, reports and display
    task automatic t_misc();
        SEQ.set_lvl(6, 1'b1);
        reg_wr(OFS_MODE, 32'h08);
        settle(1);
        `CHK("retract", 2'b11, {outs.valve_out, outs.retraction_mode})
        reg_wr(OFS_MODE, 32'h07);
        settle(1);
        `CHK("air oil", 2'b11, {outs.valve_out, outs.air_oil_retract})
        reg_wr(OFS_MODE, 32'h09);
        settle(1);
        `CHK("half cycle", 1'b1, outs.half_cycle_mode)
        SEQ.set_lvl(6, 1'b0);
        reg_wr(OFS_MODE, 32'h22);
        SEQ.meas(1'b0, 1'b1, 16'h0123);
        settle(0);
        `CHK("report last", 17'h10123, {outs.report_req, outs.report_current})
        reg_wr(OFS_MODE, 32'h23);
        SEQ.meas(1'b0, 1'b0, 16'h0456);
        settle(0);
        `CHK("no report", 1'b0, outs.report_req)
        SEQ.meas(1'b1, 1'b0, 16'h0ABC);
        settle(0);
        `CHK("report bad", 17'h10ABC, {outs.report_req, outs.report_current})
        reg_wr(OFS_MODE, 32'h25);
        SEQ.pulse(0);
        settle(0);
        `CHK("show", 3'b111, {outs.eos_indicate, outs.hi_lo_steady, outs.display_current_en})
        reg_wr(OFS_MODE, 32'h10);
        SEQ.set_lvl(11, 1'b1);
        settle(1);
        `CHK("const current", 1'b1, outs.valve_out)
        $display("test misc done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        `CHK("reset outs", 36'h0, outs)
        rst_b <= 1'b1;
        t_regs();
        t_levels();
        t_oow();
        t_seq();
        t_misc();
        finish_test();
    end
endmodule
